// file: logic/usb_endpoint_fifo_config.sv
// endpoint fifo configuration registers and layout builder
// Functional notes
// - writing one to redefine bit 0 starts a layout rebuild
// - the builder clears the redefine bit itself when the rebuild ends
// - in pipe bits 1..3 enable endpoint 1..3 input fifos, reset off
// - out pipe bits 1..3 enable endpoint 1..3 output fifos, reset off
// - out pipe bit 0 is a read/write data pid toggle bit
// - two-bit ram map picks direction of each ram block, default 00
// - endpoint 1 size bits 3:2 choose 8/16/32/64 bytes, reset 8
// - endpoint 2 size bits 5:4 choose 8/16/32/64 bytes, reset 8
// - endpoint 0 owns a fixed 8-byte fifo outside the mapping
// - default map serves inputs from ram0 and outputs from ram1
// - endpoints 1..3 share 64 bytes, plus 8 for endpoint 0
// - only endpoints 1..3 follow the enable and size registers
// - access bits 0..3 select endpoint 0..3 for firmware accesses
// - bits 7:4 of pipe enable and access registers read zero
// - tokens for a direction not enabled are ignored, endpoint kept
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_config #(
   parameter int RAM0_BYTES = 32,
   parameter int RAM1_BYTES = 32
) (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   // register port
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   // token check from the serial engine
   input wire logic I_TOKEN_VALID,
   input wire logic I_TOKEN_IS_IN,
   input wire logic [1:0] I_TOKEN_EP,
   output logic O_TOKEN_ACCEPT,
   output logic O_TOKEN_IGNORED,
   // applied layout to the serial engine
   output logic [2:0] O_IN_PIPE_ON,
   output logic [2:0] O_OUT_PIPE_ON,
   output logic [17:0] O_IN_BASE,
   output logic [17:0] O_OUT_BASE,
   output logic [20:0] O_EP_SIZE,
   output logic [3:0] O_EP0_SIZE,
   output logic O_RAM0_IS_OUT,
   output logic O_RAM1_IS_OUT,
   output logic O_DATA_PID_TOGGLE,
   output logic [3:0] O_ACCESS_SELECT,
   output logic O_LAYOUT_BUSY
);
   localparam int NE = usb_ep_fifo_cfg_pkg::NUM_CFG_EP;
   localparam logic [6:0] TOTAL =
      7'(usb_ep_fifo_cfg_pkg::SHARED_FIFO_BYTES);
   localparam logic [6:0] SPLIT = 7'(RAM0_BYTES);

   // the two blocks must fill the shared storage exactly
   if (RAM0_BYTES + RAM1_BYTES != usb_ep_fifo_cfg_pkg::SHARED_FIFO_BYTES
       || RAM0_BYTES < 0 || RAM1_BYTES < 0) begin : g_bad_split
      $error("ram block sizes must add up to the shared fifo size");
   end

   // software registers
   logic [7:0] in_pipe_enable_reg, in_pipe_enable_next;
   logic [7:0] out_pipe_enable_toggle_reg, out_pipe_enable_toggle_next;
   logic [7:0] fifo_size_control_zero_reg, fifo_size_control_zero_next;
   logic [7:0] endpoint_access_select_reg, endpoint_access_select_next;
   logic [7:0] rdata_reg, rdata_next;
   // builder state
   usb_ep_fifo_cfg_pkg::build_state_e state_reg, state_next;
   logic [1:0] idx_reg, idx_next;
   logic [6:0] in_cur_reg, in_cur_next;
   logic [6:0] out_cur_reg, out_cur_next;
   logic [6:0] in_lim_reg, in_lim_next;
   logic [6:0] out_lim_reg, out_lim_next;
   logic ovf_reg, ovf_next;
   // applied layout
   logic [NE:1] in_on_reg, in_on_next;
   logic [NE:1] out_on_reg, out_on_next;
   logic [5:0] in_base_reg [NE:1];
   logic [5:0] in_base_next [NE:1];
   logic [5:0] out_base_reg [NE:1];
   logic [5:0] out_base_next [NE:1];
   logic [6:0] size_reg [NE:1];
   logic [6:0] size_next [NE:1];
   logic [1:0] map_reg, map_next;
   // token answer
   logic tok_acc_reg, tok_acc_next;
   logic tok_ign_reg, tok_ign_next;
   // fixed and decoded outputs, held in flops so every port leaves a register
   logic [3:0] ep0_size_reg, ep0_size_next;
   logic ram1_out_reg, ram1_out_next;

   // byte size of the endpoint being placed, from its size code
   function automatic logic [6:0] size_of(input logic [7:0] ctl,
                                          input logic [1:0] ep);
      logic [1:0] code;
      code = ctl[2*ep +: 2];
      size_of = 7'(usb_ep_fifo_cfg_pkg::SIZE_MIN_BYTES) << code;
   endfunction

   always_comb begin
      logic wr_in;
      logic [6:0] sz;
      logic [3:0] dir_ok;
      wr_in = I_WR && I_ADDR == usb_ep_fifo_cfg_pkg::IN_PIPE_OFS;
      sz = size_of(fifo_size_control_zero_reg, idx_reg);
      // endpoint 0 is always open in both directions
      dir_ok = I_TOKEN_IS_IN ? {in_on_reg, 1'b1} : {out_on_reg, 1'b1};
      in_pipe_enable_next = in_pipe_enable_reg;
      out_pipe_enable_toggle_next = out_pipe_enable_toggle_reg;
      fifo_size_control_zero_next = fifo_size_control_zero_reg;
      endpoint_access_select_next = endpoint_access_select_reg;
      state_next = state_reg;
      idx_next = idx_reg;
      in_cur_next = in_cur_reg;
      out_cur_next = out_cur_reg;
      in_lim_next = in_lim_reg;
      out_lim_next = out_lim_reg;
      ovf_next = ovf_reg;
      in_on_next = in_on_reg;
      out_on_next = out_on_reg;
      in_base_next = in_base_reg;
      out_base_next = out_base_reg;
      size_next = size_reg;
      map_next = map_reg;
      // register writes, upper nibbles of the pipe and access registers are not stored
      if (wr_in) begin
         in_pipe_enable_next[3:1] = I_WDATA[3:1];
      end
      if (I_WR && I_ADDR == usb_ep_fifo_cfg_pkg::OUT_PIPE_OFS) begin
         out_pipe_enable_toggle_next = {4'h0, I_WDATA[3:0]};
      end
      if (I_WR && I_ADDR == usb_ep_fifo_cfg_pkg::SIZE_CTRL_OFS) begin
         fifo_size_control_zero_next = I_WDATA;
      end
      if (I_WR && I_ADDR == usb_ep_fifo_cfg_pkg::ACCESS_OFS) begin
         endpoint_access_select_next = {4'h0, I_WDATA[3:0]};
      end
      // layout builder
      case (state_reg)
         usb_ep_fifo_cfg_pkg::ST_IDLE: begin
            if (in_pipe_enable_reg[usb_ep_fifo_cfg_pkg::REDEF_BIT]) begin
               state_next = usb_ep_fifo_cfg_pkg::ST_STEP;
               idx_next = 2'h1;
               ovf_next = 1'b0;
               in_on_next = '0;
               out_on_next = '0;
               map_next = fifo_size_control_zero_reg[
                  usb_ep_fifo_cfg_pkg::RAM_MAP_LSB +: 2];
               // ram0 sits at 0, ram1 right after it
               case (map_next)
                  usb_ep_fifo_cfg_pkg::MAP_BOTH_OUT: begin
                     in_cur_next = 7'h00;
                     in_lim_next = 7'h00;
                     out_cur_next = 7'h00;
                     out_lim_next = TOTAL;
                  end
                  usb_ep_fifo_cfg_pkg::MAP_BOTH_IN: begin
                     in_cur_next = 7'h00;
                     in_lim_next = TOTAL;
                     out_cur_next = 7'h00;
                     out_lim_next = 7'h00;
                  end
                  usb_ep_fifo_cfg_pkg::MAP_SWAPPED: begin
                     in_cur_next = SPLIT;
                     in_lim_next = TOTAL;
                     out_cur_next = 7'h00;
                     out_lim_next = SPLIT;
                  end
                  default: begin
                     in_cur_next = 7'h00;
                     in_lim_next = SPLIT;
                     out_cur_next = SPLIT;
                     out_lim_next = TOTAL;
                  end
               endcase
            end
         end
         usb_ep_fifo_cfg_pkg::ST_STEP: begin
            // one endpoint per cycle, settings read live
            size_next[idx_reg] = sz;
            if (in_pipe_enable_reg[idx_reg]) begin
               if (8'(in_cur_reg) + 8'(sz) <= 8'(in_lim_reg)) begin
                  in_on_next[idx_reg] = 1'b1;
                  in_base_next[idx_reg] = in_cur_reg[5:0];
                  in_cur_next = in_cur_reg + sz;
               end else begin
                  ovf_next = 1'b1;
               end
            end
            if (out_pipe_enable_toggle_reg[idx_reg]) begin
               if (8'(out_cur_reg) + 8'(sz) <= 8'(out_lim_reg)) begin
                  out_on_next[idx_reg] = 1'b1;
                  out_base_next[idx_reg] = out_cur_reg[5:0];
                  out_cur_next = out_cur_reg + sz;
               end else begin
                  ovf_next = 1'b1;
               end
            end
            if (idx_reg == 2'(NE)) begin
               state_next = usb_ep_fifo_cfg_pkg::ST_DONE;
            end else begin
               idx_next = idx_reg + 2'h1;
            end
         end
         default: begin
            state_next = usb_ep_fifo_cfg_pkg::ST_IDLE;
            in_pipe_enable_next[usb_ep_fifo_cfg_pkg::REDEF_BIT] = 1'b0;
         end
      endcase
      ep0_size_next = 4'(usb_ep_fifo_cfg_pkg::EP0_FIFO_BYTES);
      ram1_out_next = map_next == usb_ep_fifo_cfg_pkg::MAP_BOTH_OUT ||
                      map_next == usb_ep_fifo_cfg_pkg::MAP_DEFAULT;
      // a fresh request in the finishing cycle survives the self clear
      if (wr_in && I_WDATA[usb_ep_fifo_cfg_pkg::REDEF_BIT]) begin
         in_pipe_enable_next[usb_ep_fifo_cfg_pkg::REDEF_BIT] = 1'b1;
      end
      tok_acc_next = I_TOKEN_VALID && dir_ok[I_TOKEN_EP];
      tok_ign_next = I_TOKEN_VALID && !dir_ok[I_TOKEN_EP];
      // read port, unmapped offsets answer zero
      rdata_next = 8'h00;
      if (I_RD) begin
         if (I_ADDR == usb_ep_fifo_cfg_pkg::IN_PIPE_OFS) begin
            rdata_next = in_pipe_enable_reg;
         end else if (I_ADDR == usb_ep_fifo_cfg_pkg::OUT_PIPE_OFS) begin
            rdata_next = out_pipe_enable_toggle_reg;
         end else if (I_ADDR == usb_ep_fifo_cfg_pkg::SIZE_CTRL_OFS) begin
            rdata_next = fifo_size_control_zero_reg;
         end else if (I_ADDR == usb_ep_fifo_cfg_pkg::ACCESS_OFS) begin
            rdata_next = endpoint_access_select_reg;
         end else if (I_ADDR == usb_ep_fifo_cfg_pkg::LAYOUT_STAT_OFS) begin
            rdata_next = {in_on_reg, out_on_reg, ovf_reg,
                          state_reg != usb_ep_fifo_cfg_pkg::ST_IDLE};
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         in_pipe_enable_reg <= usb_ep_fifo_cfg_pkg::IN_PIPE_RST;
         out_pipe_enable_toggle_reg <= usb_ep_fifo_cfg_pkg::OUT_PIPE_RST;
         fifo_size_control_zero_reg <= usb_ep_fifo_cfg_pkg::SIZE_CTRL_RST;
         endpoint_access_select_reg <= usb_ep_fifo_cfg_pkg::ACCESS_RST;
         rdata_reg <= 8'h00;
         state_reg <= usb_ep_fifo_cfg_pkg::ST_IDLE;
         idx_reg <= 2'h1;
         in_cur_reg <= 7'h00;
         out_cur_reg <= 7'h00;
         in_lim_reg <= 7'h00;
         out_lim_reg <= 7'h00;
         ovf_reg <= 1'b0;
         in_on_reg <= '0;
         out_on_reg <= '0;
         map_reg <= usb_ep_fifo_cfg_pkg::MAP_DEFAULT;
         tok_acc_reg <= 1'b0;
         tok_ign_reg <= 1'b0;
         ep0_size_reg <= 4'(usb_ep_fifo_cfg_pkg::EP0_FIFO_BYTES);
         ram1_out_reg <= 1'b1;
         for (int e = 1; e <= NE; e++) begin
            in_base_reg[e] <= 6'h00;
            out_base_reg[e] <= 6'h00;
            size_reg[e] <= 7'(usb_ep_fifo_cfg_pkg::SIZE_MIN_BYTES);
         end
      end else begin
         in_pipe_enable_reg <= in_pipe_enable_next;
         out_pipe_enable_toggle_reg <= out_pipe_enable_toggle_next;
         fifo_size_control_zero_reg <= fifo_size_control_zero_next;
         endpoint_access_select_reg <= endpoint_access_select_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
         idx_reg <= idx_next;
         in_cur_reg <= in_cur_next;
         out_cur_reg <= out_cur_next;
         in_lim_reg <= in_lim_next;
         out_lim_reg <= out_lim_next;
         ovf_reg <= ovf_next;
         in_on_reg <= in_on_next;
         out_on_reg <= out_on_next;
         map_reg <= map_next;
         tok_acc_reg <= tok_acc_next;
         tok_ign_reg <= tok_ign_next;
         ep0_size_reg <= ep0_size_next;
         ram1_out_reg <= ram1_out_next;
         in_base_reg <= in_base_next;
         out_base_reg <= out_base_next;
         size_reg <= size_next;
      end
   end

   // flatten the per-endpoint layout, endpoint 1 in the low slice
   for (genvar g = 1; g <= NE; g++) begin : g_flat
      assign O_IN_BASE[6*(g-1) +: 6] = in_base_reg[g];
      assign O_OUT_BASE[6*(g-1) +: 6] = out_base_reg[g];
      assign O_EP_SIZE[7*(g-1) +: 7] = size_reg[g];
   end

   assign O_RDATA = rdata_reg;
   assign O_TOKEN_ACCEPT = tok_acc_reg;
   assign O_TOKEN_IGNORED = tok_ign_reg;
   assign O_IN_PIPE_ON = in_on_reg;
   assign O_OUT_PIPE_ON = out_on_reg;
   assign O_EP0_SIZE = ep0_size_reg;
   assign O_RAM0_IS_OUT = map_reg[0];
   assign O_RAM1_IS_OUT = ram1_out_reg;
   assign O_DATA_PID_TOGGLE =
      out_pipe_enable_toggle_reg[usb_ep_fifo_cfg_pkg::TOGGLE_BIT];
   assign O_ACCESS_SELECT = endpoint_access_select_reg[3:0];
   assign O_LAYOUT_BUSY = in_pipe_enable_reg[usb_ep_fifo_cfg_pkg::REDEF_BIT];
endmodule // usb_endpoint_fifo_config
`default_nettype wire

// file: logic/usb_ep_fifo_cfg_pkg.sv
// constants and types shared by the endpoint fifo configuration logic
package usb_ep_fifo_cfg_pkg;
   // register offsets
   localparam logic [7:0] IN_PIPE_OFS = 8'h00;
   localparam logic [7:0] OUT_PIPE_OFS = 8'h01;
   localparam logic [7:0] SIZE_CTRL_OFS = 8'h02;
   localparam logic [7:0] ACCESS_OFS = 8'h03;
   localparam logic [7:0] LAYOUT_STAT_OFS = 8'h04;
   // reset values
   localparam logic [7:0] IN_PIPE_RST = 8'h00;
   localparam logic [7:0] OUT_PIPE_RST = 8'h00;
   localparam logic [7:0] SIZE_CTRL_RST = 8'h00;
   localparam logic [7:0] ACCESS_RST = 8'h00;
   // field positions
   localparam int REDEF_BIT = 0;
   localparam int TOGGLE_BIT = 0;
   localparam int PIPE_LSB = 1;
   localparam int RAM_MAP_LSB = 0;
   localparam int EP1_SIZE_LSB = 2;
   localparam int EP2_SIZE_LSB = 4;
   localparam int EP3_SIZE_LSB = 6;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_OVF_BIT = 1;
   // ram mapping codes
   localparam logic [1:0] MAP_DEFAULT = 2'h0;
   localparam logic [1:0] MAP_BOTH_OUT = 2'h1;
   localparam logic [1:0] MAP_BOTH_IN = 2'h2;
   localparam logic [1:0] MAP_SWAPPED = 2'h3;
   // storage figures
   localparam int EP0_FIFO_BYTES = 8;
   localparam int SHARED_FIFO_BYTES = 64;
   localparam int SIZE_MIN_BYTES = 8;
   localparam int NUM_CFG_EP = 3;
   typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_DONE} build_state_e;
endpackage

// file: testbench/usb_endpoint_fifo_config_monitor.sv
// concurrent checks on the endpoint fifo configuration ports
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_config_monitor (
   // clock, reset and register port
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] O_RDATA,
   // tokens and applied layout
   input wire logic I_TOKEN_VALID,
   input wire logic I_TOKEN_IS_IN,
   input wire logic [1:0] I_TOKEN_EP,
   input wire logic O_TOKEN_ACCEPT,
   input wire logic O_TOKEN_IGNORED,
   input wire logic [2:0] O_IN_PIPE_ON,
   input wire logic [2:0] O_OUT_PIPE_ON,
   input wire logic [3:0] O_EP0_SIZE,
   input wire logic O_DATA_PID_TOGGLE,
   input wire logic [3:0] O_ACCESS_SELECT,
   input wire logic O_LAYOUT_BUSY
);
   logic [3:0] in_on;
   logic [3:0] out_on;
   logic tok_on;
   // endpoint 0 sits in slot 0 and is always served
   assign in_on = {O_IN_PIPE_ON, 1'b1};
   assign out_on = {O_OUT_PIPE_ON, 1'b1};
   assign tok_on = I_TOKEN_IS_IN ? in_on[I_TOKEN_EP] : out_on[I_TOKEN_EP];
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   unused_bits_a: assert property (I_RD && (I_ADDR == 8'h00 || I_ADDR == 8'h01 || I_ADDR == 8'h03)
      |=> O_RDATA[7:4] == 4'h0) else $error("unused bits read nonzero");
   token_answer_a: assert property (I_TOKEN_VALID
      |=> O_TOKEN_ACCEPT == $past(tok_on) && O_TOKEN_IGNORED != $past(tok_on)) else $error("token answer wrong");
   token_quiet_a: assert property (!I_TOKEN_VALID |=> !O_TOKEN_ACCEPT && !O_TOKEN_IGNORED)
      else $error("token answer without token");
   ep0_fixed_a: assert property (O_EP0_SIZE == 4'h8) else $error("endpoint 0 size not 8");
   redef_start_a: assert property (I_WR && I_ADDR == 8'h00 && I_WDATA[0] |=> O_LAYOUT_BUSY)
      else $error("rebuild not started");
   redef_clear_a: assert property ($rose(O_LAYOUT_BUSY) |-> ##[1:12] !O_LAYOUT_BUSY)
      else $error("redefine bit not cleared");
   toggle_write_a: assert property (I_WR && I_ADDR == 8'h01 |=> O_DATA_PID_TOGGLE == $past(I_WDATA[0]))
      else $error("toggle bit not written");
   access_write_a: assert property (I_WR && I_ADDR == 8'h03 |=> O_ACCESS_SELECT == $past(I_WDATA[3:0]))
      else $error("access select not written");
   layout_hold_a: assert property (!O_LAYOUT_BUSY ##1 !O_LAYOUT_BUSY
      |-> $stable(O_IN_PIPE_ON) && $stable(O_OUT_PIPE_ON)) else $error("layout moved while idle");
endmodule // usb_endpoint_fifo_config_monitor
bind usb_endpoint_fifo_config usb_endpoint_fifo_config_monitor u_monitor (.I_REF_CLK(I_REF_CLK),
   .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .I_TOKEN_VALID(I_TOKEN_VALID), .I_TOKEN_IS_IN(I_TOKEN_IS_IN), .I_TOKEN_EP(I_TOKEN_EP),
   .O_TOKEN_ACCEPT(O_TOKEN_ACCEPT), .O_TOKEN_IGNORED(O_TOKEN_IGNORED), .O_IN_PIPE_ON(O_IN_PIPE_ON),
   .O_OUT_PIPE_ON(O_OUT_PIPE_ON), .O_EP0_SIZE(O_EP0_SIZE), .O_DATA_PID_TOGGLE(O_DATA_PID_TOGGLE),
   .O_ACCESS_SELECT(O_ACCESS_SELECT), .O_LAYOUT_BUSY(O_LAYOUT_BUSY));
`default_nettype wire

// file: testbench/usb_token_host.sv
// usb host model issuing tokens straight onto the token lines, in place of the serial engine
`timescale 1ns/1ps
`default_nettype none
module usb_token_host (
   // clock
   input wire logic clk,
   // token lines
   output logic tok_valid,
   output logic tok_is_in,
   output logic [1:0] tok_ep,
   // device answer
   input wire logic tok_accept,
   input wire logic tok_ignored
);
   initial begin
      tok_valid = 1'b0;
      tok_is_in = 1'b0;
      tok_ep = 2'h0;
   end
   task automatic send(input logic is_in, input logic [1:0] ep, output logic acc, output logic ign);
      tok_valid <= 1'b1; // a host may aim a token at a direction left off
      tok_is_in <= is_in;
      tok_ep <= ep;
      @(posedge clk);
      tok_valid <= 1'b0;
      // lines are scrambled after release so stale values cannot pass
      tok_is_in <= ~is_in;
      tok_ep <= ~ep;
      #1;
      acc = tok_accept;
      ign = tok_ignored;
   endtask
endmodule // usb_token_host
`default_nettype wire

// file: testbench/usb_endpoint_fifo_config_bench.sv
// register and token sequences for the endpoint fifo configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module usb_endpoint_fifo_config_bench;
   logic clk, rst_n, wr_s, rd_s, acc, ign, ram0_out, ram1_out, toggle, busy;
   logic tok_v, tok_in, tok_acc, tok_ign;
   logic [1:0] tok_ep;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] in_on, out_on;
   logic [17:0] in_base, out_base;
   logic [20:0] ep_size;
   logic [3:0] ep0_size, access_sel;
   int mismatches = 0;
   int n_tests = 0;
   usb_endpoint_fifo_config DUT (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_TOKEN_VALID(tok_v), .I_TOKEN_IS_IN(tok_in),
      .I_TOKEN_EP(tok_ep), .O_TOKEN_ACCEPT(tok_acc), .O_TOKEN_IGNORED(tok_ign), .O_IN_PIPE_ON(in_on),
      .O_OUT_PIPE_ON(out_on), .O_IN_BASE(in_base), .O_OUT_BASE(out_base), .O_EP_SIZE(ep_size),
      .O_EP0_SIZE(ep0_size), .O_RAM0_IS_OUT(ram0_out), .O_RAM1_IS_OUT(ram1_out),
      .O_DATA_PID_TOGGLE(toggle), .O_ACCESS_SELECT(access_sel), .O_LAYOUT_BUSY(busy));
   usb_token_host p (.clk(clk), .tok_valid(tok_v), .tok_is_in(tok_in), .tok_ep(tok_ep),
      .tok_accept(tok_acc), .tok_ignored(tok_ign));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      // step off the edge so a following call never drives the strobe twice in one time step
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      `CHK(rdata, exp)
   endtask
   // rebuild takes a handful of cycles; a stuck builder ends the run
   task automatic wait_idle;
      int i;
      i = 0;
      #1;
      while (busy !== 1'b0 && i < 20) begin
         @(posedge clk);
         #1;
         i++;
      end
      if (i == 20) begin
         mismatches++;
         give_verdict();
      end
   endtask
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(8'h00, 8'h00);
      rchk(8'h01, 8'h00);
      rchk(8'h02, 8'h00);
      rchk(8'h03, 8'h00);
      `CHK(ep_size, {7'h08, 7'h08, 7'h08})
      `CHK(ep0_size, 4'h8)
      bus_wr(8'h00, 8'hf0);
      rchk(8'h00, 8'h00);
      bus_wr(8'h01, 8'hff);
      rchk(8'h01, 8'h0f);
      `CHK(toggle, 1'b1)
      bus_wr(8'h03, 8'hfa);
      rchk(8'h03, 8'h0a);
      bus_wr(8'h07, 8'h55);
      rchk(8'h07, 8'h00);
      bus_wr(8'h01, 8'h02);
      rchk(8'h01, 8'h02);
      `CHK(toggle, 1'b0)
      for (int c = 0; c < 4; c++) begin
         bus_wr(8'h02, {c[1:0], c[1:0], c[1:0], 2'h0});
         rchk(8'h02, {c[1:0], c[1:0], c[1:0], 2'h0});
         bus_wr(8'h00, 8'h03);
         wait_idle();
         rchk(8'h00, 8'h02);
         `CHK(ep_size[6:0], 7'(8 << c))
         `CHK(ep_size[13:7], 7'(8 << c))
         `CHK(ep_size[20:14], 7'(8 << c))
         // a 64-byte pipe cannot fit a 32-byte ram half
         `CHK(in_on, (c == 3) ? 3'h0 : 3'h1)
         `CHK(out_on, (c == 3) ? 3'h0 : 3'h1)
         if (c < 3) begin
            `CHK(in_base[5:0], 6'h00)
            `CHK(out_base[5:0], 6'h20)
         end
      end
      // status after the oversized rebuild: both pipes off, overflow set, idle
      rchk(8'h04, 8'h02);
      for (int m = 0; m < 4; m++) begin
         bus_wr(8'h02, {6'h00, m[1:0]});
         bus_wr(8'h00, 8'h03);
         wait_idle();
         `CHK(ram0_out, m[0])
         `CHK(ram1_out, ~m[1])
      end
      `CHK(in_base[5:0], 6'h20)
      for (int t = 0; t < 8; t++) begin
         p.send(t[2], t[1:0], acc, ign);
         `CHK(acc, t[1:0] <= 2'h1)
         `CHK(ign, t[1:0] > 2'h1)
      end
      `CHK(in_on, 3'h1)
      bus_wr(8'h03, 8'h03);
      rchk(8'h03, 8'h03);
      `CHK(access_sel, 4'h3)
      give_verdict();
   end
endmodule // usb_endpoint_fifo_config_bench
`undef CHK
`default_nettype wire
